/* File: pwm_pkg.sv */
// Package for the phase wake-up measurement register block.
// Assumes one 125 MHz clock and a seven-bit register address whose top bit selects space B.
package pwm_pkg;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [6:0] ADDR_AMP_AVG = 7'h35;
  localparam logic [6:0] ADDR_AMP_LAST = 7'h36;
  localparam logic [6:0] ADDR_PH_CFG = 7'h37;
  localparam logic [6:0] ADDR_PH_REF = 7'h38;
  localparam logic [6:0] ADDR_PH_AVG = 7'h39;
  localparam logic [6:0] ADDR_PH_LAST = 7'h3A;
  localparam logic [6:0] ADDR_IRQ_STAT = 7'h3C;
  localparam logic [6:0] ADDR_IRQ_MASK = 7'h3D;
  localparam logic [6:0] ADDR_CTRL = 7'h3E;
  localparam logic [6:0] SPACE_B = 7'h40;
  localparam logic [6:0] ADDR_TRIM = SPACE_B | 7'h39;

  // ==========================================================================
  // Reset values and field positions
  // ==========================================================================
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [2:0] RST_TRIM = 3'h0;
  localparam logic RST_BIT = 1'b0;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_PHASE_BIT = 1;
  localparam int IRQ_AMP_BIT = 2;
  localparam int CTRL_WAKE_MODE_BIT = 0;
  localparam logic [2:0] BASE_SHIFT = 3'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [3:0] phase_delta_threshold;
    logic include_trigger_sample;
    logic [1:0] average_weight_select;
    logic reference_source_select;
  } pwm_cfg_type;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } pwm_sample_type;

  typedef enum logic [1:0] {
    PWM_IDLE = 2'b00,
    PWM_COMPARE = 2'b01,
    PWM_UPDATE = 2'b10
  } pwm_state_type;

  // Weight code 00..11 gives 4, 8, 16, 32, that is a right shift of 2..5.
  function automatic logic [2:0] weight_shift(input logic [1:0] code);
    weight_shift = BASE_SHIFT + {1'b0, code};
  endfunction

endpackage

/* File: pwm_avg.sv */
// Running average of eight-bit samples with a power-of-two weight.
// Assumes samples arrive as one-cycle strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pwm_avg (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sample in
  input wire logic load,
  input wire logic [7:0] sample,
  input wire logic [1:0] weight,
  // Average out
  output logic [7:0] avg
);
  logic [7:0] avg_reg;
  logic [7:0] avg_next;
  logic signed [9:0] diff;
  logic signed [9:0] step;

  // ==========================================================================
  // Averaging step
  // ==========================================================================
  // The newest sample moves the average by one weight-th of the gap.
  always_comb begin
    diff = $signed({2'b00, sample}) - $signed({2'b00, avg_reg});
    step = diff >>> pwm_pkg::weight_shift(weight);
    avg_next = 8'(avg_reg + step[7:0]);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avg_reg <= pwm_pkg::RST_BYTE;
    end else if (load) begin
      avg_reg <= avg_next;
    end
  end

  assign avg = avg_reg;
endmodule
`default_nettype wire

/* File: pwm_cmp.sv */
// Absolute difference of a phase sample to a reference against a threshold.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module pwm_cmp (
  // Operands
  input wire logic [7:0] sample,
  input wire logic [7:0] reference,
  input wire logic [3:0] threshold,
  // Result
  output logic exceeds
);
  logic [7:0] delta;

  // ==========================================================================
  // Compare
  // ==========================================================================
  always_comb begin
    if (sample >= reference) begin
      delta = sample - reference;
    end else begin
      delta = reference - sample;
    end
    exceeds = delta > {4'h0, threshold};
  end
endmodule
`default_nettype wire

/* File: pwm_top.sv */
// Phase wake-up measurement registers: readouts, configuration and wake-up compare.
// Assumes measurement results and the trim code come from logic on CLK.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pwm_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Measurement results
  input wire logic PHASE_VALID,
  input wire logic [7:0] PHASE_DATA,
  input wire logic AMP_VALID,
  input wire logic [7:0] AMP_DATA,
  input wire logic [2:0] OSC_TRIM,
  // Interrupt
  output logic IRQ
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  pwm_pkg::pwm_cfg_type cfg_reg;
  pwm_pkg::pwm_state_type state_reg;
  pwm_pkg::pwm_state_type state_next;
  pwm_pkg::pwm_sample_type phase_in;
  pwm_pkg::pwm_sample_type amp_in;
  logic [7:0] phase_ref_value_reg;
  logic [7:0] phase_last_value_reg;
  logic [7:0] amplitude_last_value_reg;
  logic [2:0] osc_trim_readout_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic ctrl_wake_reg;
  logic trigger_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic [7:0] phase_avg_value;
  logic [7:0] amp_avg_value;
  logic [7:0] compare_ref;
  logic exceeds;
  logic phase_load;
  logic [2:0] irq_set;
  logic wr_cfg;
  logic wr_ref;
  logic wr_stat;
  logic wr_mask;
  logic wr_ctrl;
  logic [2:0] irq_stat_next;

  // A strobe that hits one register address.
  function automatic logic addr_hit(input logic strobe, input logic [6:0] addr,
    input logic [6:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  assign phase_in = '{valid: PHASE_VALID, value: PHASE_DATA};
  assign amp_in = '{valid: AMP_VALID, value: AMP_DATA};

  // ==========================================================================
  // Write decode
  // ==========================================================================
  // Read-only addresses decode to nothing, so writes there are dropped.
  always_comb begin
    wr_cfg = addr_hit(WR, ADDR, pwm_pkg::ADDR_PH_CFG);
    wr_ref = addr_hit(WR, ADDR, pwm_pkg::ADDR_PH_REF);
    wr_stat = addr_hit(WR, ADDR, pwm_pkg::ADDR_IRQ_STAT);
    wr_mask = addr_hit(WR, ADDR, pwm_pkg::ADDR_IRQ_MASK);
    wr_ctrl = addr_hit(WR, ADDR, pwm_pkg::ADDR_CTRL);
  end

  // ==========================================================================
  // Configuration register
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_reg <= pwm_pkg::pwm_cfg_type'(pwm_pkg::RST_BYTE);
    end else if (wr_cfg) begin
      // Every field takes its bits straight from the written byte.
      cfg_reg <= pwm_pkg::pwm_cfg_type'(WDATA);
    end
  end

  // ==========================================================================
  // Phase reference register
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_ref_value_reg <= pwm_pkg::RST_BYTE;
    end else if (wr_ref) begin
      phase_ref_value_reg <= WDATA;
    end
  end

  // ==========================================================================
  // Wake-up mode control
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_wake_reg <= pwm_pkg::RST_BIT;
    end else if (wr_ctrl) begin
      // Compares raise no wake-up while this bit is clear.
      ctrl_wake_reg <= WDATA[pwm_pkg::CTRL_WAKE_MODE_BIT];
    end
  end

  // ==========================================================================
  // Latest measurement readouts
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      amplitude_last_value_reg <= pwm_pkg::RST_BYTE;
    end else if (amp_in.valid) begin
      amplitude_last_value_reg <= amp_in.value;
    end
  end

  // A sample arriving while the previous one is still in flight is dropped.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_last_value_reg <= pwm_pkg::RST_BYTE;
    end else if (phase_in.valid && state_reg == pwm_pkg::PWM_IDLE) begin
      phase_last_value_reg <= phase_in.value;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_trim_readout_reg <= pwm_pkg::RST_TRIM;
    end else begin
      osc_trim_readout_reg <= OSC_TRIM;
    end
  end

  // ==========================================================================
  // Averagers
  // ==========================================================================
  // Amplitude average always takes every sample; its weight follows the phase weight.
  pwm_avg u_amp_avg (
    .clk(CLK),
    .resetn(RESETN),
    .load(amp_in.valid),
    .sample(amp_in.value),
    .weight(cfg_reg.average_weight_select),
    .avg(amp_avg_value)
  );

  // The phase average folds in the captured sample, not the live input bus.
  pwm_avg u_phase_avg (
    .clk(CLK),
    .resetn(RESETN),
    .load(phase_load),
    .sample(phase_last_value_reg),
    .weight(cfg_reg.average_weight_select),
    .avg(phase_avg_value)
  );

  // ==========================================================================
  // Wake-up compare
  // ==========================================================================
  always_comb begin
    if (cfg_reg.reference_source_select) begin
      // This is the average before the new sample is folded in.
      compare_ref = phase_avg_value;
    end else begin
      compare_ref = phase_ref_value_reg;
    end
  end

  pwm_cmp u_cmp (
    .sample(phase_last_value_reg),
    .reference(compare_ref),
    .threshold(cfg_reg.phase_delta_threshold),
    .exceeds(exceeds)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Capture, then compare against the reference register or the old average, then fold the sample in unless it triggered and the include bit is clear.
  always_comb begin
    case (state_reg)
      pwm_pkg::PWM_IDLE: begin
        if (phase_in.valid) begin
          state_next = pwm_pkg::PWM_COMPARE;
        end else begin
          state_next = pwm_pkg::PWM_IDLE;
        end
      end
      pwm_pkg::PWM_COMPARE: begin
        state_next = pwm_pkg::PWM_UPDATE;
      end
      pwm_pkg::PWM_UPDATE: begin
        state_next = pwm_pkg::PWM_IDLE;
      end
      default: begin
        state_next = pwm_pkg::PWM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= pwm_pkg::PWM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The trigger is only meaningful in wake-up mode.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trigger_reg <= pwm_pkg::RST_BIT;
    end else if (state_reg == pwm_pkg::PWM_COMPARE) begin
      trigger_reg <= ctrl_wake_reg && exceeds;
    end
  end

  // A triggering sample enters the average only when the include bit is set.
  always_comb begin
    phase_load = (state_reg == pwm_pkg::PWM_UPDATE) &&
                 (!trigger_reg || cfg_reg.include_trigger_sample);
  end

  // ==========================================================================
  // Interrupt status and mask
  // ==========================================================================
  always_comb begin
    irq_set = 3'h0;
    irq_set[pwm_pkg::IRQ_WAKE_BIT] = (state_reg == pwm_pkg::PWM_UPDATE) && trigger_reg;
    irq_set[pwm_pkg::IRQ_PHASE_BIT] = state_reg == pwm_pkg::PWM_UPDATE;
    irq_set[pwm_pkg::IRQ_AMP_BIT] = amp_in.valid;
  end

  // Writing one clears a bit, but an event in the same cycle keeps it set.
  always_comb begin
    irq_stat_next = (irq_stat_reg & ~(wr_stat ? WDATA[2:0] : 3'h0)) | irq_set;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_stat_reg <= pwm_pkg::RST_IRQ;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_mask_reg <= pwm_pkg::RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_reg <= WDATA[2:0];
    end
  end

  // Uses the next status so the line follows the sticky bits without lag.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_reg <= pwm_pkg::RST_BIT;
    end else begin
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Read mux
  // ==========================================================================
  // Unmapped addresses and reserved bits read as zero.
  always_comb begin
    case (ADDR)
      pwm_pkg::ADDR_AMP_AVG: begin
        rdata_next = amp_avg_value;
      end
      pwm_pkg::ADDR_AMP_LAST: begin
        rdata_next = amplitude_last_value_reg;
      end
      pwm_pkg::ADDR_PH_CFG: begin
        rdata_next = cfg_reg;
      end
      pwm_pkg::ADDR_PH_REF: begin
        rdata_next = phase_ref_value_reg;
      end
      pwm_pkg::ADDR_PH_AVG: begin
        rdata_next = phase_avg_value;
      end
      pwm_pkg::ADDR_PH_LAST: begin
        rdata_next = phase_last_value_reg;
      end
      pwm_pkg::ADDR_TRIM: begin
        rdata_next = {5'h00, osc_trim_readout_reg};
      end
      pwm_pkg::ADDR_IRQ_STAT: begin
        rdata_next = {5'h00, irq_stat_reg};
      end
      pwm_pkg::ADDR_IRQ_MASK: begin
        rdata_next = {5'h00, irq_mask_reg};
      end
      pwm_pkg::ADDR_CTRL: begin
        rdata_next = {7'h00, ctrl_wake_reg};
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= pwm_pkg::RST_BYTE;
    end else if (RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign RDATA = rdata_reg;
  assign IRQ = irq_reg;
endmodule
`default_nettype wire

/* File: pwm_chk.sv */
// Port checker for the phase wake-up measurement register block.
// Assumes it is bound to pwm_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pwm_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Measurements and interrupt
  input wire logic PHASE_VALID,
  input wire logic [7:0] PHASE_DATA,
  input wire logic AMP_VALID,
  input wire logic [7:0] AMP_DATA,
  input wire logic [2:0] OSC_TRIM,
  input wire logic IRQ
);
  // ==========================================================================
  // Sequences
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence wr_ref_s; WR && ADDR == pwm_pkg::ADDR_PH_REF; endsequence
  sequence rd_ref_s; RD && ADDR == pwm_pkg::ADDR_PH_REF; endsequence
  sequence wr_cfg_s; WR && ADDR == pwm_pkg::ADDR_PH_CFG; endsequence
  sequence rd_cfg_s; RD && ADDR == pwm_pkg::ADDR_PH_CFG; endsequence

  // ==========================================================================
  // Assertions
  write_no_data_a:
    assert property (WR |=> RDATA == 8'h00) else $error("read data after a write");
  trim_read_a:
    assert property (RD && ADDR == pwm_pkg::ADDR_TRIM |=> RDATA == {5'h00, $past(OSC_TRIM, 2)})
    else $error("trim readout wrong");
  ref_readback_a:
    assert property (wr_ref_s ##1 !WR ##1 rd_ref_s |=> RDATA == $past(WDATA, 3))
    else $error("phase reference readback wrong");
  cfg_readback_a:
    assert property (wr_cfg_s ##1 !WR ##1 rd_cfg_s |=> RDATA == $past(WDATA, 3))
    else $error("phase config readback wrong");
  amp_last_a:
    assert property (AMP_VALID ##1 !AMP_VALID ##1 (RD && ADDR == pwm_pkg::ADDR_AMP_LAST)
      |=> RDATA == $past(AMP_DATA, 3)) else $error("latest amplitude wrong");
  irq_rise_a:
    assert property ($rose(IRQ) |-> $past(AMP_VALID) || $past(PHASE_VALID, 3) ||
      $past(PHASE_VALID, 4) || $past(WR) || $past(WR, 2)) else $error("interrupt without cause");
  irq_fall_a:
    assert property ($fell(IRQ) |-> $past(WR) || $past(WR, 2))
    else $error("interrupt dropped without a write");
  irq_hold_a:
    assert property ((IRQ && !WR) [*2] |=> IRQ) else $error("interrupt not sticky");
endmodule
`default_nettype wire

/* File: test_phase_wakeup_measure_regs.sv */
// Self-checking bench for the phase wake-up measurement register block.
// Assumes pwm_top and pwm_chk are compiled beside it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_phase_wakeup_measure_regs;
  logic CLK, RESETN, WR, RD, PHASE_VALID, AMP_VALID, IRQ;
  logic [6:0] ADDR;
  logic [7:0] WDATA, RDATA, PHASE_DATA, AMP_DATA;
  logic [2:0] OSC_TRIM;
  int miscompares = 0;
  int samples_checked = 0;

  // ==========================================================================
  // Clock and design
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  pwm_top DUT (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PHASE_VALID(PHASE_VALID), .PHASE_DATA(PHASE_DATA),
    .AMP_VALID(AMP_VALID), .AMP_DATA(AMP_DATA), .OSC_TRIM(OSC_TRIM), .IRQ(IRQ));

  // ==========================================================================
  // Bus and sample tasks
  task automatic do_reset;
    RESETN <= 1'b0;
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK(RDATA, e)
  endtask
  task automatic irqc(input logic e);
    @(posedge CLK);
    #1;
    `CHK(IRQ, e)
  endtask
  // The sequencer is busy for two cycles, so each sample waits before returning.
  task automatic ph(input logic [7:0] s);
    @(posedge CLK);
    PHASE_VALID <= 1'b1;
    PHASE_DATA <= s;
    @(posedge CLK);
    PHASE_VALID <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task automatic amp(input logic [7:0] s);
    @(posedge CLK);
    AMP_VALID <= 1'b1;
    AMP_DATA <= s;
    @(posedge CLK);
    AMP_VALID <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_resets;
    logic [6:0] ro [5];
    ro = '{7'h35, 7'h36, 7'h39, 7'h3A, 7'h79};
    for (int i = 'h35; i <= 'h3E; i++) rdc(7'(i), 8'h00);
    rdc(pwm_pkg::ADDR_TRIM, 8'h03);
    foreach (ro[i]) wr(ro[i], 8'hFF);
    foreach (ro[i]) rdc(ro[i], (ro[i] == pwm_pkg::ADDR_TRIM) ? 8'h03 : 8'h00);
  endtask
  task automatic t_rw;
    do_reset;
    wr(pwm_pkg::ADDR_PH_REF, 8'hA5);
    rdc(pwm_pkg::ADDR_PH_REF, 8'hA5);
    wr(pwm_pkg::ADDR_PH_CFG, 8'h5A);
    rdc(pwm_pkg::ADDR_PH_CFG, 8'h5A);
  endtask
  task automatic t_amp;
    do_reset;
    amp(8'h40);
    rdc(pwm_pkg::ADDR_AMP_LAST, 8'h40);
    rdc(pwm_pkg::ADDR_AMP_AVG, 8'h10);
    wr(pwm_pkg::ADDR_AMP_AVG, 8'hFF);
    rdc(pwm_pkg::ADDR_AMP_AVG, 8'h10);
    rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h04);
    irqc(1'b0);
    wr(pwm_pkg::ADDR_IRQ_MASK, 8'h04);
    irqc(1'b1);
    wr(pwm_pkg::ADDR_IRQ_STAT, 8'h04);
    irqc(1'b0);
  endtask
  task automatic t_weights;
    for (int w = 0; w < 4; w++) begin
      do_reset;
      wr(pwm_pkg::ADDR_PH_CFG, {5'h00, 2'(w), 1'b0});
      ph(8'h80);
      rdc(pwm_pkg::ADDR_PH_AVG, 8'h80 >> (w + 2));
      rdc(pwm_pkg::ADDR_PH_LAST, 8'h80);
      rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h02);
    end
  endtask
  task automatic t_wake;
    do_reset;
    wr(pwm_pkg::ADDR_CTRL, 8'h01);
    wr(pwm_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(pwm_pkg::ADDR_PH_REF, 8'h20);
    wr(pwm_pkg::ADDR_PH_CFG, 8'h40);
    ph(8'h24);
    rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(pwm_pkg::ADDR_IRQ_STAT, 8'h02);
    ph(8'h25);
    irqc(1'b1);
    rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h03);
    rdc(pwm_pkg::ADDR_PH_AVG, 8'h09);
    rdc(pwm_pkg::ADDR_PH_LAST, 8'h25);
    wr(pwm_pkg::ADDR_IRQ_STAT, 8'h03);
    irqc(1'b0);
    wr(pwm_pkg::ADDR_PH_CFG, 8'h48);
    ph(8'h25);
    rdc(pwm_pkg::ADDR_PH_AVG, 8'h10);
  endtask
  task automatic t_refsel;
    do_reset;
    wr(pwm_pkg::ADDR_CTRL, 8'h01);
    wr(pwm_pkg::ADDR_PH_REF, 8'h80);
    wr(pwm_pkg::ADDR_PH_CFG, 8'h41);
    ph(8'h02);
    rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(pwm_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(pwm_pkg::ADDR_PH_CFG, 8'h40);
    ph(8'h02);
    rdc(pwm_pkg::ADDR_IRQ_STAT, 8'h03);
  endtask

  // ==========================================================================
  // Run control
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    RESETN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 7'h00;
    WDATA = 8'h00;
    PHASE_VALID = 1'b0;
    PHASE_DATA = 8'h00;
    AMP_VALID = 1'b0;
    AMP_DATA = 8'h00;
    OSC_TRIM = 3'h3;
    do_reset;
    t_resets;
    t_rw;
    t_amp;
    t_weights;
    t_wake;
    t_refsel;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    complete_run;
  end
endmodule
bind pwm_top pwm_chk CHK (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .PHASE_VALID(PHASE_VALID), .PHASE_DATA(PHASE_DATA),
  .AMP_VALID(AMP_VALID), .AMP_DATA(AMP_DATA), .OSC_TRIM(OSC_TRIM), .IRQ(IRQ));
`default_nettype wire
